// >>> logic/lpc_channel_address_decode.sv
// Host I/O cycle decoder for channels 2 to 4 and the bidirectional window, plus its cycle FIFO.
// Assumes host cycles arrive synchronous to hclk and software programs it over AHB-Lite.
// Function
// - Channel 2 write match stores input byte; address bit 2 tags data or command.
// - Channel 4 read returns output byte if bit 2 is 0, status otherwise.
// - Channel 3 address is high byte 15:8, low byte 7:3 and 1; reset zero.
// - Channel 3 addresses are compared only while channel 3 is enabled.
// - Channel 3 match forces programmed bit 0 to zero and ignores bit 2.
// - Bidirectional window matches with bit 4 inverted; bits 3:0 pick the index.
// - Index 0 splits into host-to-slave and slave-to-host bytes; 1..15 shared.
// - Low byte bit 0 enables the bidirectional window; resets to zero.
// - Channel 4 address stores all bits; bit 2 is left out of the match.
// - Input bytes are 8 bits, host written, software read, not reset.
// - A matching channel 2, 3 or 4 input write latches address bit 2 into that channel's command flag; window writes leave the flags alone.
// - Output bytes are 8 bits, host read only, returned on a matching read.
`timescale 1ns/10ps
`default_nettype none

module cycle_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic [PW:0]      next_count;
  logic             push;
  logic             pop;
  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign out_data = store[rd_ptr];
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end
  // Flags are registered from the next count so both stay honest every cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      count     <= next_count;
      in_ready  <= next_count != (PW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge hclk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end
endmodule

module lpc_channel_address_decode #(
  parameter int FIFO_DEPTH = lpc_decode_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  // AHB-Lite slave.
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic      [31:0]                  hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  // Host I/O cycles in.
  input  wire logic                         io_valid,
  output logic                              io_ready,
  input  wire lpc_decode_pkg::io_cycle_type io_cycle,
  // Host answers out.
  output logic                              resp_valid,
  input  wire logic                         resp_ready,
  output lpc_decode_pkg::io_resp_type       resp
);
  localparam int CW = $bits(lpc_decode_pkg::io_cycle_type);
  // Software registers.
  logic [2:0]  ctrl;
  logic [15:0] chan2_base_addr;
  logic [7:0]  chan3_base_addr_high;
  logic [7:0]  chan3_base_addr_low;
  logic [7:0]  chan4_base_addr_high;
  logic [7:0]  chan4_base_addr_low;
  logic [7:0]  chan2_host_out_byte;
  logic [7:0]  chan3_host_out_byte;
  logic [7:0]  chan4_host_out_byte;
  logic [7:0]  bidir_slave_to_host_byte;
  // Host-written state.
  logic [7:0]  chan2_host_in_byte;
  logic [7:0]  chan3_host_in_byte;
  logic [7:0]  chan4_host_in_byte;
  logic [7:0]  bidir_host_to_slave_byte;
  logic [7:0]  bidir_shared_bytes [1:15];
  logic [2:0]  cmd_flag;
  // Bus data-phase state.
  logic        dp_pending;
  logic        dp_write;
  logic [7:0]  dp_addr;
  logic        sw_wr;
  // Decode of the cycle at the FIFO head.
  lpc_decode_pkg::io_cycle_type head;
  logic        head_valid;
  logic        take;
  logic [15:0] chan3_base_addr;
  logic [15:0] chan4_base_addr;
  logic        chan3_enable;
  logic        chan4_enable;
  logic        bidir_window_enable;
  logic        hit2;
  logic        hit3;
  logic        hitw;
  logic        hit4;
  logic [3:0]  widx;
  logic [7:0]  host_rdata;
  logic        host_wr;
  function automatic logic [7:0] state_byte(input logic cd);
    state_byte = '0;
    state_byte[lpc_decode_pkg::STATE_CD_BIT] = cd;
  endfunction
  cycle_fifo #(.WIDTH(CW), .DEPTH(FIFO_DEPTH)) cycles (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (io_valid),
    .in_ready  (io_ready),
    .in_data   (io_cycle),
    .out_valid (head_valid),
    .out_ready (take),
    .out_data  (head)
  );
  assign chan3_base_addr     = {chan3_base_addr_high, chan3_base_addr_low};
  assign chan4_base_addr     = {chan4_base_addr_high, chan4_base_addr_low};
  assign chan3_enable        = ctrl[lpc_decode_pkg::CTRL_CHAN3_EN];
  assign chan4_enable        = ctrl[lpc_decode_pkg::CTRL_CHAN4_EN];
  assign bidir_window_enable = chan3_base_addr_low[lpc_decode_pkg::BIDIR_EN_BIT];
  assign widx                = head.addr[3:0];
  assign take                = head_valid && (!resp_valid || resp_ready);
  // Channel matches ignore address bit 2, which only selects the register.
  always_comb begin
    hit2 = ctrl[lpc_decode_pkg::CTRL_CHAN2_EN]
        && {head.addr[15:3], head.addr[1:0]} == {chan2_base_addr[15:3], chan2_base_addr[1:0]};
    hit3 = chan3_enable
        && {head.addr[15:3], head.addr[1:0]} == {chan3_base_addr[15:3], chan3_base_addr[1], 1'b0};
    hitw = chan3_enable && bidir_window_enable
        && head.addr[15:lpc_decode_pkg::WINDOW_BIT]
           == {chan3_base_addr[15:lpc_decode_pkg::BIDIR_INV_BIT+1],
               ~chan3_base_addr[lpc_decode_pkg::BIDIR_INV_BIT]};
    hit4 = chan4_enable
        && {head.addr[15:3], head.addr[1:0]} == {chan4_base_addr[15:3], chan4_base_addr[1:0]};
  end
  // Overlapping matches resolve in channel order; software keeps them apart.
  always_comb begin
    host_rdata = '0;
    if (hit2) begin
      host_rdata = head.addr[lpc_decode_pkg::CMD_BIT] ? state_byte(cmd_flag[0]) : chan2_host_out_byte;
    end else if (hit3) begin
      host_rdata = head.addr[lpc_decode_pkg::CMD_BIT] ? state_byte(cmd_flag[1]) : chan3_host_out_byte;
    end else if (hitw) begin
      host_rdata = (widx == '0) ? bidir_slave_to_host_byte : bidir_shared_bytes[widx];
    end else if (hit4) begin
      host_rdata = head.addr[lpc_decode_pkg::CMD_BIT] ? state_byte(cmd_flag[2]) : chan4_host_out_byte;
    end
  end
  assign host_wr = take && head.write;
  // Answers hold until the host side accepts them; a stall here fills the FIFO.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resp_valid <= 1'b0;
      resp       <= '0;
    end else if (take) begin
      resp_valid   <= 1'b1;
      resp.claimed <= hit2 || hit3 || hitw || hit4;
      resp.rdata   <= head.write ? '0 : host_rdata;
    end else if (resp_ready) begin
      resp_valid <= 1'b0;
    end
  end
  // Input bytes carry no reset value.
  always_ff @(posedge hclk) begin
    if (host_wr) begin
      if (hit2) begin
        chan2_host_in_byte <= head.data;
      end else if (hit3) begin
        chan3_host_in_byte <= head.data;
      end else if (hitw && widx == '0) begin
        bidir_host_to_slave_byte <= head.data;
      end else if (!hitw && hit4) begin
        chan4_host_in_byte <= head.data;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_flag <= '0;
    end else if (host_wr) begin
      if (hit2) begin
        cmd_flag[0] <= head.addr[lpc_decode_pkg::CMD_BIT];
      end else if (hit3) begin
        cmd_flag[1] <= head.addr[lpc_decode_pkg::CMD_BIT];
      end else if (!hitw && hit4) begin
        cmd_flag[2] <= head.addr[lpc_decode_pkg::CMD_BIT];
      end
    end
  end
  // Shared bytes are written by both sides; the host wins a same-cycle clash.
  always_ff @(posedge hclk) begin
    if (sw_wr && dp_addr[7:6] == lpc_decode_pkg::BIDIR_PAGE && dp_addr[5:2] != '0) begin
      bidir_shared_bytes[dp_addr[5:2]] <= hwdata[7:0];
    end
    if (host_wr && !hit2 && !hit3 && hitw && widx != '0) begin
      bidir_shared_bytes[widx] <= head.data;
    end
  end
  // Every transfer takes one wait state so that read data leaves a flip-flop.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_pending <= 1'b0;
      dp_write   <= 1'b0;
      dp_addr    <= '0;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else if (hsel && htrans[1] && hready && hreadyout) begin
      dp_pending <= 1'b1;
      dp_write   <= hwrite;
      dp_addr    <= haddr[7:0];
      hreadyout  <= 1'b0;
    end else if (dp_pending) begin
      dp_pending <= 1'b0;
      hreadyout  <= 1'b1;
    end
  end
  assign sw_wr = dp_pending && dp_write;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl                     <= lpc_decode_pkg::CTRL_RESET;
      chan2_base_addr          <= lpc_decode_pkg::CHAN2_BASE_RESET;
      chan3_base_addr_high     <= lpc_decode_pkg::BYTE_RESET;
      chan3_base_addr_low      <= lpc_decode_pkg::BYTE_RESET;
      chan4_base_addr_high     <= lpc_decode_pkg::BYTE_RESET;
      chan4_base_addr_low      <= lpc_decode_pkg::BYTE_RESET;
      chan2_host_out_byte      <= lpc_decode_pkg::BYTE_RESET;
      chan3_host_out_byte      <= lpc_decode_pkg::BYTE_RESET;
      chan4_host_out_byte      <= lpc_decode_pkg::BYTE_RESET;
      bidir_slave_to_host_byte <= lpc_decode_pkg::BYTE_RESET;
    end else if (sw_wr) begin
      unique case (dp_addr)
        lpc_decode_pkg::OFF_CTRL:       ctrl                     <= hwdata[2:0];
        lpc_decode_pkg::OFF_CHAN2_BASE: chan2_base_addr          <= hwdata[15:0];
        lpc_decode_pkg::OFF_CHAN3_HIGH: chan3_base_addr_high     <= hwdata[7:0];
        lpc_decode_pkg::OFF_CHAN3_LOW:  chan3_base_addr_low      <= hwdata[7:0];
        lpc_decode_pkg::OFF_CHAN4_HIGH: chan4_base_addr_high     <= hwdata[7:0];
        lpc_decode_pkg::OFF_CHAN4_LOW:  chan4_base_addr_low      <= hwdata[7:0];
        lpc_decode_pkg::OFF_CHAN2_OUT:  chan2_host_out_byte      <= hwdata[7:0];
        lpc_decode_pkg::OFF_CHAN3_OUT:  chan3_host_out_byte      <= hwdata[7:0];
        lpc_decode_pkg::OFF_CHAN4_OUT:  chan4_host_out_byte      <= hwdata[7:0];
        lpc_decode_pkg::OFF_BIDIR0:     bidir_slave_to_host_byte <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (dp_pending && !dp_write) begin
      hrdata <= '0;
      if (dp_addr[7:6] == lpc_decode_pkg::BIDIR_PAGE) begin
        hrdata[7:0] <= (dp_addr[5:2] == '0) ? 8'h00 : bidir_shared_bytes[dp_addr[5:2]];
      end else begin
        unique case (dp_addr)
          lpc_decode_pkg::OFF_CTRL:       hrdata[2:0]  <= ctrl;
          lpc_decode_pkg::OFF_CHAN2_BASE: hrdata[15:0] <= chan2_base_addr;
          lpc_decode_pkg::OFF_CHAN3_HIGH: hrdata[7:0]  <= chan3_base_addr_high;
          lpc_decode_pkg::OFF_CHAN3_LOW:  hrdata[7:0]  <= chan3_base_addr_low;
          lpc_decode_pkg::OFF_CHAN4_HIGH: hrdata[7:0]  <= chan4_base_addr_high;
          lpc_decode_pkg::OFF_CHAN4_LOW:  hrdata[7:0]  <= chan4_base_addr_low;
          lpc_decode_pkg::OFF_CHAN2_OUT:  hrdata[7:0]  <= chan2_host_out_byte;
          lpc_decode_pkg::OFF_CHAN3_OUT:  hrdata[7:0]  <= chan3_host_out_byte;
          lpc_decode_pkg::OFF_CHAN4_OUT:  hrdata[7:0]  <= chan4_host_out_byte;
          lpc_decode_pkg::OFF_CHAN2_IN:   hrdata[7:0]  <= chan2_host_in_byte;
          lpc_decode_pkg::OFF_CHAN3_IN:   hrdata[7:0]  <= chan3_host_in_byte;
          lpc_decode_pkg::OFF_CHAN4_IN:   hrdata[7:0]  <= chan4_host_in_byte;
          lpc_decode_pkg::OFF_STATE:      hrdata[2:0]  <= cmd_flag;
          lpc_decode_pkg::OFF_BIDIR0:     hrdata[7:0]  <= bidir_host_to_slave_byte;
          default: ;
        endcase
      end
    end
  end
endmodule

`default_nettype wire

// >>> logic/lpc_decode_pkg.sv
// Constants, register map and carrier types for the LPC channel address decoder.
// Assumes a 32-bit AHB-Lite register bus and byte-wide host I/O cycles.
package lpc_decode_pkg;

  // Register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] OFF_CTRL          = 8'h00;
  localparam logic [7:0] OFF_CHAN2_BASE    = 8'h04;
  localparam logic [7:0] OFF_CHAN3_HIGH    = 8'h08;
  localparam logic [7:0] OFF_CHAN3_LOW     = 8'h0C;
  localparam logic [7:0] OFF_CHAN4_HIGH    = 8'h10;
  localparam logic [7:0] OFF_CHAN4_LOW     = 8'h14;
  localparam logic [7:0] OFF_CHAN2_OUT     = 8'h18;
  localparam logic [7:0] OFF_CHAN3_OUT     = 8'h1C;
  localparam logic [7:0] OFF_CHAN4_OUT     = 8'h20;
  localparam logic [7:0] OFF_CHAN2_IN      = 8'h24;
  localparam logic [7:0] OFF_CHAN3_IN      = 8'h28;
  localparam logic [7:0] OFF_CHAN4_IN      = 8'h2C;
  localparam logic [7:0] OFF_STATE         = 8'h30;
  localparam logic [7:0] OFF_BIDIR0        = 8'h34;
  // Shared bidirectional bytes 1..15 sit in page BIDIR_PAGE of offset bits 7:6, at 4 * index within it.
  localparam logic [1:0] BIDIR_PAGE        = 2'h1;

  // Control register bit positions.
  localparam int CTRL_CHAN2_EN = 0;
  localparam int CTRL_CHAN3_EN = 1;
  localparam int CTRL_CHAN4_EN = 2;

  // Host address, window enable and status byte bit positions used in decoding.
  localparam int CMD_BIT       = 2;
  localparam int BIDIR_INV_BIT = 4;
  localparam int WINDOW_BIT    = 4;
  localparam int BIDIR_EN_BIT  = 0;
  localparam int STATE_CD_BIT  = 3;

  // Reset values.
  localparam logic [15:0] CHAN2_BASE_RESET = 16'h0062;
  localparam logic [7:0]  BYTE_RESET       = 8'h00;
  localparam logic [2:0]  CTRL_RESET       = 3'h0;

  localparam int FIFO_DEPTH = 4;

  typedef struct packed {
    logic        write;
    logic [15:0] addr;
    logic [7:0]  data;
  } io_cycle_type;

  typedef struct packed {
    logic       claimed;
    logic [7:0] rdata;
  } io_resp_type;

endpackage

// >>> bench/lpc_decode_sva.sv
// Checker for the decoder's bus timing, answer holding and channel 3/4 decode results.
// Sees only the top ports; it shadows software register writes to know what was programmed.
`timescale 1ns/10ps
`default_nettype none
module lpc_decode_sva (
  // Clock and reset.
  input wire logic                         hclk,
  input wire logic                         hresetn,
  // Register bus.
  input wire logic                         hsel,
  input wire logic [31:0]                  haddr,
  input wire logic [1:0]                   htrans,
  input wire logic                         hwrite,
  input wire logic [31:0]                  hwdata,
  input wire logic                         hready,
  input wire logic                         hreadyout,
  input wire logic                         hresp,
  // Host side.
  input wire logic                         io_valid,
  input wire logic                         io_ready,
  input wire lpc_decode_pkg::io_cycle_type io_cycle,
  input wire logic                         resp_valid,
  input wire logic                         resp_ready,
  input wire lpc_decode_pkg::io_resp_type  resp
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [7:0]                   sh [0:15];
  logic [7:0]                   wa;
  logic                         wp;
  logic                         pv;
  lpc_decode_pkg::io_cycle_type lc;
  wire logic tk = hsel && htrans[1] && hready && hreadyout;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp <= 1'h0;
      wa <= 8'h00;
      for (int i = 0; i < 16; i++) sh[i] <= 8'h00;
    end else begin
      wp <= tk && hwrite && haddr[7:6] == 2'h0;
      if (tk) wa <= haddr[7:0];
      if (wp) sh[wa[5:2]] <= hwdata[7:0];
    end
  end
  // The last accepted cycle is the one answered when an answer newly appears.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pv <= 1'h0;
      lc <= '0;
    end else begin
      pv <= resp_valid;
      if (io_valid && io_ready) lc <= io_cycle;
    end
  end
  wire logic nw = resp_valid && !pv;
  wire logic rd = nw && !lc.write;
  wire logic m4 = sh[0][2:0] == 3'h4 && lc.addr[15:8] == sh[4] && lc.addr[7:3] == sh[5][7:3]
                  && lc.addr[1:0] == sh[5][1:0];
  wire logic m3 = sh[0][2:0] == 3'h2 && !sh[3][0] && lc.addr[15:8] == sh[2]
                  && lc.addr[7:3] == sh[3][7:3] && lc.addr[1:0] == {sh[3][1], 1'h0};
  sequence s_taken;
    tk;
  endsequence
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_bus_wait: assert property (s_taken |=> s_wait)
    else $error("bus transfer without its single wait state");
  a_resp_okay: assert property (hresp == 1'h0)
    else $error("bus response not okay");
  a_answer_holds: assert property (resp_valid && !resp_ready |=> resp_valid && $stable(resp))
    else $error("host answer changed while stalled");
  a_idle_unclaimed: assert property (nw && sh[0][2:0] == 3'h0 |-> resp == '0)
    else $error("cycle claimed with every channel off");
  a_write_silent: assert property (nw && lc.write |-> resp.rdata == 8'h00)
    else $error("write answer carried data");
  a_chan4_claim: assert property (nw && m4 |-> resp.claimed)
    else $error("channel 4 match not claimed");
  a_chan4_output: assert property (rd && m4 && !lc.addr[2] |-> resp.rdata == sh[8])
    else $error("channel 4 output byte wrong");
  a_chan4_status: assert property (rd && m4 && lc.addr[2] |-> resp.rdata[7:4] == 4'h0 && resp.rdata[2:0] == 3'h0)
    else $error("channel 4 status byte wrong");
  a_chan3_output: assert property (rd && m3 && !lc.addr[2] |-> resp.claimed && resp.rdata == sh[7])
    else $error("channel 3 output byte wrong");
endmodule
bind lpc_channel_address_decode lpc_decode_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hresp, .io_valid, .io_ready, .io_cycle, .resp_valid, .resp_ready, .resp);
`default_nettype wire

// >>> bench/lpc_host_model.sv
// Host chipset model: offers I/O cycles one at a time and collects the answers.
// Assumes the bench calls push and sets stall to hold answers back.
`timescale 1ns/10ps
`default_nettype none
module lpc_host_model (
  // Clock and reset.
  input wire logic                         hclk,
  input wire logic                         hresetn,
  // Cycle offer.
  output logic                             io_valid = 1'h0,
  input wire logic                         io_ready,
  output lpc_decode_pkg::io_cycle_type     io_cycle = '0,
  // Answer take.
  input wire logic                         resp_valid,
  output logic                             resp_ready,
  input wire lpc_decode_pkg::io_resp_type  resp
);
  logic                        stall = 1'h0;
  logic                        late = 1'h0;
  lpc_decode_pkg::io_resp_type got [$];
  assign resp_ready = !stall;
  always @(posedge hclk) begin
    if (hresetn && resp_valid && resp_ready) got.push_back(resp);
  end
  // Held until taken; afterwards the released lines show the inverse value.
  task automatic push(input lpc_decode_pkg::io_cycle_type c);
    int n;
    @(posedge hclk);
    io_valid <= 1'h1;
    io_cycle <= c;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (io_ready !== 1'h1 && n < 64);
    if (io_ready !== 1'h1) late = 1'h1;
    io_valid <= 1'h0;
    io_cycle <= ~c;
  endtask
endmodule
`default_nettype wire

// >>> bench/tb_lpc_channel_address_decode.sv
// Self-checking bench for the channel decoder: registers over AHB-Lite, cycles via the host model.
// Assumes the checker is bound into the design and the host model answers with resp_ready.
`timescale 1ns/10ps
`default_nettype none
module tb_lpc_channel_address_decode;
  logic                         hclk = 1'h0;
  logic                         hresetn = 1'h0;
  logic [31:0]                  haddr = 32'h0;
  logic [31:0]                  hwdata = 32'h0;
  logic [1:0]                   htrans = 2'h0;
  logic                         hwrite = 1'h0;
  wire logic                    hready;
  logic [31:0]                  hrdata;
  logic                         hreadyout, hresp, io_valid, io_ready, resp_valid, resp_ready;
  lpc_decode_pkg::io_cycle_type io_cycle;
  lpc_decode_pkg::io_resp_type  resp;
  int                           miscompares = 0;
  int                           checks_done = 0;
  always #4 hclk = ~hclk;
  assign hready = hreadyout;
  lpc_channel_address_decode #(.FIFO_DEPTH(4)) dut (.hclk, .hresetn, .hsel(1'h1), .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp, .io_valid, .io_ready,
    .io_cycle, .resp_valid, .resp_ready, .resp);
  lpc_host_model host (.hclk, .hresetn, .io_valid, .io_ready, .io_cycle, .resp_valid, .resp_ready,
    .resp);
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 64);
    if (hreadyout !== 1'h1) begin
      miscompares++;
      wrap_up;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(1'h1, a, {24'h0, d}, x);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] x;
    bus(1'h0, a, 32'h0, x);
    check(x, {24'h0, e});
  endtask
  // Expected answer e is the claim flag above the returned byte.
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [8:0] e);
    int n;
    host.push({w, a, d});
    n = 0;
    while (host.got.size() == 0 && n < 64) begin
      @(posedge hclk);
      n++;
    end
    if (host.got.size() == 0) begin
      miscompares++;
      wrap_up;
    end
    check({23'h0, host.got.pop_front()}, {23'h0, e});
  endtask
  task automatic t_reset;
    rd(lpc_decode_pkg::OFF_CTRL, 8'h00);
    rd(lpc_decode_pkg::OFF_CHAN2_BASE, 8'h62);
    rd(lpc_decode_pkg::OFF_CHAN3_HIGH, 8'h00);
    rd(lpc_decode_pkg::OFF_CHAN3_LOW, 8'h00);
    rd(lpc_decode_pkg::OFF_CHAN4_HIGH, 8'h00);
    rd(lpc_decode_pkg::OFF_CHAN4_LOW, 8'h00);
    rd(lpc_decode_pkg::OFF_STATE, 8'h00);
    rd(8'hFC, 8'h00);
    io(1'h1, 16'h0062, 8'h12, 9'h000);
    $display("test reset done");
  endtask
  task automatic t_chan2;
    wr(lpc_decode_pkg::OFF_CTRL, 8'h01);
    wr(lpc_decode_pkg::OFF_CHAN2_OUT, 8'h3C);
    io(1'h1, 16'h0062, 8'hA5, 9'h100);
    rd(lpc_decode_pkg::OFF_CHAN2_IN, 8'hA5);
    rd(lpc_decode_pkg::OFF_STATE, 8'h00);
    io(1'h1, 16'h0066, 8'h5A, 9'h100);
    rd(lpc_decode_pkg::OFF_CHAN2_IN, 8'h5A);
    rd(lpc_decode_pkg::OFF_STATE, 8'h01);
    io(1'h0, 16'h0062, 8'h00, 9'h13C);
    io(1'h0, 16'h0066, 8'h00, 9'h108);
    io(1'h1, 16'h0063, 8'h77, 9'h000);
    rd(lpc_decode_pkg::OFF_CHAN2_IN, 8'h5A);
    rd(lpc_decode_pkg::OFF_CHAN2_OUT, 8'h3C);
    wr(lpc_decode_pkg::OFF_CTRL, 8'h00);
    wr(lpc_decode_pkg::OFF_CHAN2_BASE, 8'hE2);
    wr(lpc_decode_pkg::OFF_CTRL, 8'h01);
    io(1'h0, 16'h00E6, 8'h00, 9'h108);
    io(1'h0, 16'h0062, 8'h00, 9'h000);
    $display("test chan2 done");
  endtask
  task automatic t_chan3;
    wr(lpc_decode_pkg::OFF_CTRL, 8'h00);
    wr(lpc_decode_pkg::OFF_CHAN3_HIGH, 8'h0A);
    wr(lpc_decode_pkg::OFF_CHAN3_LOW, 8'hA3);
    rd(lpc_decode_pkg::OFF_CHAN3_LOW, 8'hA3);
    io(1'h1, 16'h0AA2, 8'h11, 9'h000);
    wr(lpc_decode_pkg::OFF_CTRL, 8'h02);
    wr(lpc_decode_pkg::OFF_CHAN3_OUT, 8'hC3);
    io(1'h1, 16'h0AA6, 8'h22, 9'h100);
    rd(lpc_decode_pkg::OFF_CHAN3_IN, 8'h22);
    rd(lpc_decode_pkg::OFF_STATE, 8'h03);
    io(1'h0, 16'h0AA2, 8'h00, 9'h1C3);
    io(1'h0, 16'h0AA3, 8'h00, 9'h000);
    io(1'h0, 16'h0AA6, 8'h00, 9'h108);
    io(1'h1, 16'h0AB0, 8'h44, 9'h100);
    rd(lpc_decode_pkg::OFF_BIDIR0, 8'h44);
    wr(lpc_decode_pkg::OFF_BIDIR0, 8'h55);
    io(1'h0, 16'h0AB0, 8'h00, 9'h155);
    io(1'h1, 16'h0ABF, 8'h66, 9'h100);
    rd(8'h7C, 8'h66);
    wr(8'h48, 8'h99);
    io(1'h0, 16'h0AB2, 8'h00, 9'h199);
    wr(lpc_decode_pkg::OFF_CTRL, 8'h00);
    wr(lpc_decode_pkg::OFF_CHAN3_LOW, 8'hA2);
    wr(lpc_decode_pkg::OFF_CTRL, 8'h02);
    io(1'h0, 16'h0ABF, 8'h00, 9'h000);
    io(1'h0, 16'h0AA2, 8'h00, 9'h1C3);
    $display("test chan3 done");
  endtask
  task automatic t_chan4;
    wr(lpc_decode_pkg::OFF_CTRL, 8'h00);
    wr(lpc_decode_pkg::OFF_CHAN4_HIGH, 8'h03);
    wr(lpc_decode_pkg::OFF_CHAN4_LOW, 8'h14);
    rd(lpc_decode_pkg::OFF_CHAN4_LOW, 8'h14);
    wr(lpc_decode_pkg::OFF_CHAN4_OUT, 8'h4D);
    wr(lpc_decode_pkg::OFF_CTRL, 8'h04);
    io(1'h0, 16'h0310, 8'h00, 9'h14D);
    io(1'h1, 16'h0314, 8'h88, 9'h100);
    rd(lpc_decode_pkg::OFF_CHAN4_IN, 8'h88);
    rd(lpc_decode_pkg::OFF_STATE, 8'h07);
    io(1'h0, 16'h0314, 8'h00, 9'h108);
    io(1'h1, 16'h0310, 8'h89, 9'h100);
    io(1'h0, 16'h0314, 8'h00, 9'h100);
    io(1'h0, 16'h0311, 8'h00, 9'h000);
    $display("test chan4 done");
  endtask
  task automatic t_fifo;
    int n;
    wr(lpc_decode_pkg::OFF_CTRL, 8'h00);
    host.stall <= 1'h1;
    // One cycle sits in the answer slot, the FIFO holds the rest.
    repeat (5) host.push({1'h0, 16'h1234, 8'h00});
    @(posedge hclk);
    check({31'h0, io_ready}, 32'h0);
    host.stall <= 1'h0;
    n = 0;
    while (host.got.size() < 5 && n < 64) begin
      @(posedge hclk);
      n++;
    end
    check(host.got.size(), 5);
    while (host.got.size() > 0) check({23'h0, host.got.pop_front()}, 32'h0);
    check({31'h0, io_ready}, 32'h1);
    $display("test fifo done");
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    t_reset;
    t_chan2;
    t_chan3;
    t_chan4;
    t_fifo;
    check({31'h0, host.late}, 32'h0);
    wrap_up;
  end
endmodule
`default_nettype wire
